// *** src/luf_pkg.sv ***
// Package of constants and types for the lookup index and unknown forwarding block
//
// Summary of operation
// - Almost-full static write stores 12-bit entry address
// - Failed static write stores 10-bit bucket address unless almost-full fires in the same cycle
// - Learn fail on full static bucket stores bucket
// - Every host table access while clk_en is high stores its bucket
// - Precedence: unknown VLAN, then unicast, then multicast
// - Unicast forwarding only while its enable is set
// - Multicast forwarding only while its enable is set
// - VLAN forwarding only while its enable is set
// - All ones forwards everywhere, zeros nowhere
// - Three sticky event flags, write-one clear, masked
package luf_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] LUF_IDX0_INDEX    = 12'h0316;
    localparam logic [11:0] LUF_IDX1_INDEX    = 12'h0318;
    localparam logic [11:0] LUF_IDX2_INDEX    = 12'h031a;
    localparam logic [11:0] LUF_UCAST_INDEX   = 12'h0320;
    localparam logic [11:0] LUF_MCAST_INDEX   = 12'h0324;
    localparam logic [11:0] LUF_VLAN_INDEX    = 12'h0328;
    localparam logic [11:0] LUF_INT_INDEX     = 12'h0314;
    localparam logic [11:0] LUF_MASK_INDEX    = 12'h0315;
    localparam logic [13:0] LUF_IDX0_ADDR     = {LUF_IDX0_INDEX, 2'b00};
    localparam logic [13:0] LUF_IDX1_ADDR     = {LUF_IDX1_INDEX, 2'b00};
    localparam logic [13:0] LUF_IDX2_ADDR     = {LUF_IDX2_INDEX, 2'b00};
    localparam logic [13:0] LUF_UCAST_ADDR    = {LUF_UCAST_INDEX, 2'b00};
    localparam logic [13:0] LUF_MCAST_ADDR    = {LUF_MCAST_INDEX, 2'b00};
    localparam logic [13:0] LUF_VLAN_ADDR     = {LUF_VLAN_INDEX, 2'b00};
    localparam logic [13:0] LUF_INT_ADDR      = {LUF_INT_INDEX, 2'b00};
    localparam logic [13:0] LUF_MASK_ADDR     = {LUF_MASK_INDEX, 2'b00};
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          LUF_EN_BIT        = 31;
    localparam int          LUF_PORTS         = 7;
    localparam int          LUF_ENTRY_W       = 12;
    localparam int          LUF_BUCKET_W      = 10;
    localparam int          LUF_LEARN_BIT     = 2;
    localparam int          LUF_AFULL_BIT     = 1;
    localparam int          LUF_WFAIL_BIT     = 0;
    localparam logic [15:0] LUF_IDX_RST       = 16'h0000;
    localparam logic [31:0] LUF_CTRL_RST      = 32'h0000_0000;
    localparam logic [2:0]  LUF_INT_RST       = 3'h0;
    localparam logic [2:0]  LUF_MASK_RST      = 3'h7;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic                    en;
        logic [LUF_PORTS-1:0]    ports;
    } luf_ctrl_t;
    typedef struct packed {
        logic                    valid;
        logic                    vlan;
        logic                    ucast;
        logic                    mcast;
    } luf_pkt_t;
    typedef enum logic [1:0] {
        LUF_CAT_NONE,
        LUF_CAT_VLAN,
        LUF_CAT_UCAST,
        LUF_CAT_MCAST
    } luf_cat_t;
endpackage : luf_pkg

// *** src/luf_regs.sv ***
// Lookup index registers, unknown forwarding controls and port decision
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module luf_regs (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  clk_en,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [15:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  afull_evt,
    input  wire logic [luf_pkg::LUF_ENTRY_W-1:0]       afull_entry,
    input  wire logic                                  wfail_evt,
    input  wire logic [luf_pkg::LUF_BUCKET_W-1:0]      wfail_bucket,
    input  wire logic                                  learn_fail_evt,
    input  wire logic [luf_pkg::LUF_BUCKET_W-1:0]      learn_fail_bucket,
    input  wire logic                                  host_acc_evt,
    input  wire logic [luf_pkg::LUF_BUCKET_W-1:0]      host_acc_bucket,
    input  wire luf_pkg::luf_pkt_t                     pkt_in,
    output luf_pkg::luf_cat_t                          fwd_cat,
    output logic                                       fwd_valid,
    output logic      [luf_pkg::LUF_PORTS-1:0]         fwd_ports,
    output logic                                       irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]              idx0_reg;
    logic [15:0]              idx1_reg;
    logic [15:0]              idx2_reg;
    luf_pkg::luf_ctrl_t       ucast_reg;
    luf_pkg::luf_ctrl_t       mcast_reg;
    luf_pkg::luf_ctrl_t       vlan_reg;
    logic [2:0]               int_reg;
    logic [2:0]               mask_reg;
    logic [2:0]               int_next;
    logic [2:0]               evt_vec;
    logic [2:0]               w1c;
    logic [31:0]              rd_next;
    logic                     hit;
    logic                     acc;
    logic                     wr;
    logic [13:0]              a;
    luf_pkg::luf_cat_t        cat_next;
    logic [6:0]               ports_next;
    logic                     fv_next;

    assign a   = paddr[13:0];
    assign acc = psel && penable && !pready && clk_en;
    assign wr  = psel && penable && pready && pwrite && hit && clk_en;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        hit     = 1'b1;
        rd_next = 32'h0000_0000;
        case (a)
            luf_pkg::LUF_IDX0_ADDR:  rd_next[15:0] = idx0_reg;
            luf_pkg::LUF_IDX1_ADDR:  rd_next[15:0] = idx1_reg;
            luf_pkg::LUF_IDX2_ADDR:  rd_next[15:0] = idx2_reg;
            luf_pkg::LUF_UCAST_ADDR: rd_next = {ucast_reg.en, 24'h00_0000, ucast_reg.ports};
            luf_pkg::LUF_MCAST_ADDR: rd_next = {mcast_reg.en, 24'h00_0000, mcast_reg.ports};
            luf_pkg::LUF_VLAN_ADDR:  rd_next = {vlan_reg.en, 24'h00_0000, vlan_reg.ports};
            luf_pkg::LUF_INT_ADDR:   rd_next[2:0] = int_reg;
            luf_pkg::LUF_MASK_ADDR:  rd_next[2:0] = mask_reg;
            default:                 hit = 1'b0;
        endcase
        if (paddr[15:14] != 2'b00) begin
            hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB handshake, one wait state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= acc;
            pslverr <= acc && !hit;
            if (acc && !pwrite) begin
                prdata <= hit ? rd_next : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Index registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx0_reg <= luf_pkg::LUF_IDX_RST;
            idx1_reg <= luf_pkg::LUF_IDX_RST;
            idx2_reg <= luf_pkg::LUF_IDX_RST;
        end else if (clk_en) begin
            if (afull_evt) begin
                idx0_reg <= {4'h0, afull_entry};
            end else if (wfail_evt) begin
                idx0_reg <= {6'h00, wfail_bucket};
            end
            if (learn_fail_evt) begin
                idx1_reg <= {6'h00, learn_fail_bucket};
            end
            if (host_acc_evt) begin
                idx2_reg <= {6'h00, host_acc_bucket};
            end
        end
    end

    // ------------------------------------------------------------
    // Forwarding control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ucast_reg <= {luf_pkg::LUF_CTRL_RST[31], luf_pkg::LUF_CTRL_RST[6:0]};
            mcast_reg <= {luf_pkg::LUF_CTRL_RST[31], luf_pkg::LUF_CTRL_RST[6:0]};
            vlan_reg  <= {luf_pkg::LUF_CTRL_RST[31], luf_pkg::LUF_CTRL_RST[6:0]};
            mask_reg  <= luf_pkg::LUF_MASK_RST;
        end else if (wr) begin
            case (a)
                luf_pkg::LUF_UCAST_ADDR: ucast_reg <= {pwdata[luf_pkg::LUF_EN_BIT], pwdata[6:0]};
                luf_pkg::LUF_MCAST_ADDR: mcast_reg <= {pwdata[luf_pkg::LUF_EN_BIT], pwdata[6:0]};
                luf_pkg::LUF_VLAN_ADDR:  vlan_reg  <= {pwdata[luf_pkg::LUF_EN_BIT], pwdata[6:0]};
                luf_pkg::LUF_MASK_ADDR:  mask_reg  <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sticky interrupt flags, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        evt_vec = 3'h0;
        evt_vec[luf_pkg::LUF_LEARN_BIT] = learn_fail_evt;
        evt_vec[luf_pkg::LUF_AFULL_BIT] = afull_evt;
        evt_vec[luf_pkg::LUF_WFAIL_BIT] = wfail_evt;
        w1c      = (wr && a == luf_pkg::LUF_INT_ADDR) ? pwdata[2:0] : 3'h0;
        int_next = (int_reg & ~w1c) | evt_vec;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_reg <= luf_pkg::LUF_INT_RST;
            irq     <= 1'b0;
        end else if (clk_en) begin
            int_reg <= int_next;
            irq     <= |(int_next & ~mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Unknown-category forwarding decision
    // ------------------------------------------------------------
    always_comb begin
        cat_next   = luf_pkg::LUF_CAT_NONE;
        ports_next = 7'h00;
        fv_next    = pkt_in.valid;
        if (pkt_in.vlan) begin
            cat_next   = luf_pkg::LUF_CAT_VLAN;
            ports_next = vlan_reg.en ? vlan_reg.ports : 7'h00;
        end else if (pkt_in.ucast) begin
            cat_next   = luf_pkg::LUF_CAT_UCAST;
            ports_next = ucast_reg.en ? ucast_reg.ports : 7'h00;
        end else if (pkt_in.mcast) begin
            cat_next   = luf_pkg::LUF_CAT_MCAST;
            ports_next = mcast_reg.en ? mcast_reg.ports : 7'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_cat   <= luf_pkg::LUF_CAT_NONE;
            fwd_valid <= 1'b0;
            fwd_ports <= 7'h00;
        end else if (clk_en) begin
            fwd_cat   <= cat_next;
            fwd_valid <= fv_next;
            fwd_ports <= ports_next;
        end
    end
endmodule : luf_regs

// *** test/luf_regs_sva.sv ***
// Concurrent checks on the lookup index and unknown forwarding ports
`timescale 1ns/10ps
module luf_regs_sva (
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input luf_pkg::luf_pkt_t pkt_in,
    input luf_pkg::luf_cat_t fwd_cat,
    input logic [luf_pkg::LUF_PORTS-1:0] fwd_ports
);
    logic live;
    // Checks start one edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !live);
    sequence s_vlan_idle;
        clk_en && pkt_in.valid && pkt_in.vlan && !psel;
    endsequence
    sequence s_vlan_twice;
        s_vlan_idle ##1 s_vlan_idle;
    endsequence
    a_apb_wait_state: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("no ready after access");
    a_idle_no_ready: assert property (!psel && clk_en |=> !pready)
        else $error("ready without select");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_prec_vlan: assert property (clk_en && pkt_in.valid && pkt_in.vlan
        |=> fwd_cat == luf_pkg::LUF_CAT_VLAN) else $error("vlan not first");
    a_prec_ucast: assert property (clk_en && pkt_in.valid && !pkt_in.vlan && pkt_in.ucast
        |=> fwd_cat == luf_pkg::LUF_CAT_UCAST) else $error("unicast not second");
    a_prec_mcast: assert property (clk_en && pkt_in.valid && !pkt_in.vlan && !pkt_in.ucast
        && pkt_in.mcast |=> fwd_cat == luf_pkg::LUF_CAT_MCAST) else $error("multicast lost");
    a_no_cat_quiet: assert property (clk_en && pkt_in.valid && !pkt_in.vlan && !pkt_in.ucast
        && !pkt_in.mcast |=> fwd_ports == 7'h00) else $error("ports without category");
    a_vlan_ports_hold: assert property (s_vlan_twice |=> $stable(fwd_ports))
        else $error("vlan ports changed without write");
endmodule : luf_regs_sva
bind luf_regs luf_regs_sva luf_regs_sva_inst (.*);

// *** test/luf_regs_tb_top.sv ***
// Self-checking bench of the lookup index and unknown forwarding block
`timescale 1ns/10ps
module luf_regs_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, err, pready, pslverr, irq, fwd_valid;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic afull_evt = 1'b0, wfail_evt = 1'b0, learn_fail_evt = 1'b0, host_acc_evt = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, x, v, vold, seed = 32'h0000_96c2;
    logic [11:0] afull_entry = 12'h000;
    logic [9:0] wfail_bucket = 10'h000, learn_fail_bucket = 10'h000, host_acc_bucket = 10'h000;
    logic [6:0] fwd_ports;
    logic [31:0] ctl [3];
    luf_pkg::luf_pkt_t pkt_in = 4'h0;
    luf_pkg::luf_cat_t fwd_cat;
    int mismatches = 0, n_tests = 0;
    logic [13:0] ra [8] = '{luf_pkg::LUF_IDX0_ADDR, luf_pkg::LUF_IDX1_ADDR, luf_pkg::LUF_IDX2_ADDR,
        luf_pkg::LUF_UCAST_ADDR, luf_pkg::LUF_MCAST_ADDR, luf_pkg::LUF_VLAN_ADDR,
        luf_pkg::LUF_INT_ADDR, luf_pkg::LUF_MASK_ADDR};
    luf_regs luf_regs_inst (.*);
    always #12.5 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [8:0] fwd_exp(input logic [2:0] p);
        logic [1:0] c;
        c = p[2] ? 2'h1 : p[1] ? 2'h2 : p[0] ? 2'h3 : 2'h0;
        if (c == 2'h0 || !ctl[c - 1][31]) return {c, 7'h00};
        return {c, ctl[c - 1][6:0]};
    endfunction : fwd_exp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        x = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        @(posedge pclk);
    endtask : apb
    task automatic ev(input logic [3:0] w);
        {afull_evt, wfail_evt, learn_fail_evt, host_acc_evt} <= w;
        afull_entry <= v[11:0];
        wfail_bucket <= ~v[9:0];
        learn_fail_bucket <= v[9:0];
        host_acc_bucket <= v[9:0];
        @(posedge pclk);
        {afull_evt, wfail_evt, learn_fail_evt, host_acc_evt} <= 4'h0;
        @(posedge pclk);
    endtask : ev
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, {2'b00, ra[0]}, 32'hFFFF_FFFF);
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, {2'b00, ra[k]}, 32'h0000_0000);
            check(x, {29'h0, (k == 7) ? 3'h7 : 3'h0});
        end
        apb(1'b0, 16'h4000, 32'h0000_0000);
        check({x[30:0], err}, 32'h0000_0001);
        apb(1'b1, 16'h4000, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        $display("done: reset values");
        for (int k = 0; k < 8; k++) begin
            v = rnd();
            ev(4'b1000);
            apb(1'b0, {2'b00, ra[0]}, 32'h0000_0000);
            check(x, {20'h0, v[11:0]});
            ev(4'b0100);
            apb(1'b0, {2'b00, ra[0]}, 32'h0000_0000);
            check(x, {22'h0, ~v[9:0]});
            ev(4'b0011);
            apb(1'b0, {2'b00, ra[1]}, 32'h0000_0000);
            check(x, {22'h0, v[9:0]});
            apb(1'b0, {2'b00, ra[2]}, 32'h0000_0000);
            check(x, {22'h0, v[9:0]});
            ev(4'b1100);
            apb(1'b0, {2'b00, ra[1]}, 32'h0000_0000);
            check(x, {22'h0, v[9:0]});
            apb(1'b0, {2'b00, ra[0]}, 32'h0000_0000);
            check(x, {20'h0, v[11:0]});
        end
        apb(1'b0, {2'b00, ra[6]}, 32'h0000_0000);
        check(x, 32'h0000_0007);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, {2'b00, ra[7]}, 32'h0000_0006);
        apb(1'b1, {2'b00, ra[6]}, 32'h0000_0006);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0000_0001);
        @(posedge pclk);
        apb(1'b1, {2'b00, ra[6]}, 32'h0000_0001);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        @(posedge pclk);
        vold = v;
        clk_en <= 1'b0;
        v = rnd();
        ev(4'b1111);
        clk_en <= 1'b1;
        apb(1'b0, {2'b00, ra[1]}, 32'h0000_0000);
        check(x, {22'h0, vold[9:0]});
        apb(1'b0, {2'b00, ra[6]}, 32'h0000_0000);
        check(x, 32'h0000_0000);
        $display("done: events and interrupt");
        for (int k = 0; k < 12; k++) begin
            for (int j = 0; j < 3; j++) begin
                ctl[j] = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h8000_0000 : rnd();
                apb(1'b1, {2'b00, ra[(j == 0) ? 5 : j + 2]}, ctl[j]);
                apb(1'b0, {2'b00, ra[(j == 0) ? 5 : j + 2]}, 32'h0000_0000);
                check(x, ctl[j] & 32'h8000_007F);
            end
            for (int p = 0; p < 8; p++) begin
                v = rnd() | ((k < 2) ? 32'h0000_0001 : 32'h0000_0000);
                pkt_in <= {v[0], p[2:0]};
                @(posedge pclk);
                @(negedge pclk);
                x = {22'h0, v[0], fwd_exp(p[2:0])};
                check({22'h0, fwd_valid, fwd_cat, fwd_ports}, x);
                @(posedge pclk);
            end
        end
        $display("done: forwarding");
        presetn <= 1'b0;
        @(negedge pclk);
        check({22'h0, fwd_valid, fwd_cat, fwd_ports}, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, {2'b00, ra[k]}, 32'h0000_0000);
            check(x, {29'h0, (k == 7) ? 3'h7 : 3'h0});
        end
        $display("done: reset in mid-run");
        report_and_stop();
    end
endmodule : luf_regs_tb_top
